// ### design/flag_bank_cfg.svh
`ifndef FLAG_BANK_CFG_SVH
`define FLAG_BANK_CFG_SVH

// register offsets
`define FLAGS_ZERO_OFFSET 8'h22
`define FLAGS_ONE_OFFSET  8'h23
`define FLAGS_TWO_OFFSET  8'h24

// power-on value of every flag register
`define FLAGS_RESET_VALUE 8'h00

// bit positions in flags_zero
`define BIT_INPUT_BUS_PRESENCE   0
`define BIT_ADAPTER_ONE_PRESENCE 1

// bit positions in flags_one
`define BIT_CHARGER_DETECT       0
`define BIT_BATTERY_PRESENCE     1
`define BIT_THERMAL_REGULATION   2
`define BIT_INPUT_BUS_STATE      4
`define BIT_CURRENT_OPTIMIZER    6
`define BIT_CHARGE_STATE         7

// bit positions in flags_two
`define BIT_TOPOFF_TIMEOUT       0
`define BIT_PRECHARGE_TIMEOUT    1
`define BIT_TRICKLE_TIMEOUT      2
`define BIT_FAST_CHARGE_TIMEOUT  3
`define BIT_MIN_SYSTEM_VOLTAGE   4
`define BIT_CONVERSION_DONE      5
`define BIT_DATA_LINE_DONE       6

// implemented bits; all others read zero
`define FLAGS_ZERO_MASK 8'h03
`define FLAGS_ONE_MASK  8'hd7
`define FLAGS_TWO_MASK  8'h7f

`endif

// ### design/flag_bank_pkg.sv
package flag_bank_pkg;

   typedef logic [7:0] reg_byte_t;

   typedef enum {
      detect_any_change,
      detect_rising_edge
   } edge_mode_t;

endpackage : flag_bank_pkg

// ### design/change_detector.sv
`include "flag_bank_cfg.svh"

// one-cycle event on a change (or a rising edge) of a synchronous status input;
// the first cycle after reset only primes the history so power-on levels raise nothing
module change_detector
   import flag_bank_pkg::*;
#(
   parameter int         WIDTH = 1,
   parameter edge_mode_t MODE  = detect_any_change
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] status,
   output logic                  event_pulse
);

   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;
   logic             primed_reg;
   logic             primed_next;

   always_comb begin
      prev_next   = status;
      primed_next = 1'b1;
      case (MODE)
         detect_rising_edge: begin
            event_pulse = primed_reg && (|(status & ~prev_reg));
         end
         default: begin
            event_pulse = primed_reg && (status != prev_reg);
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg   <= '0;
         primed_reg <= 1'b0;
      end else begin
         prev_reg   <= prev_next;
         primed_reg <= primed_next;
      end
   end

endmodule : change_detector

// ### design/charger_event_flag_bank.sv
`include "flag_bank_cfg.svh"

// Behaviour
// - adapter one presence change sets bit one
// - input bus presence change sets bit zero
// - charge status change sets bit seven
// - optimizer status change sets bit six
// - input bus status change sets bit four
// - thermal regulation rising edge sets bit two
// - battery presence change sets bit one
// - charger detection status change sets bit zero
// - register 0x23 resets zero, bits 5,3 zero
// - register 0x24 resets zero, bit 7 zero
// - data line detection completion sets bit six
// - single-mode conversion completion sets bit five
// - minimum system voltage regulation change sets bit four
// - fast charge timer rising edge sets bit three
// - trickle timer rising edge sets bit two
// - precharge timer rising edge sets bit one
// - topoff timer rising edge sets bit zero
module charger_event_flag_bank
   import flag_bank_pkg::*;
#(
   parameter int CHARGE_STATUS_WIDTH    = 3,
   parameter int OPTIMIZER_STATUS_WIDTH = 2,
   parameter int BUS_STATUS_WIDTH       = 4,
   parameter int DETECT_STATUS_WIDTH    = 2
) (
   input  wire logic                              clock,
   input  wire logic                              rst_n,
   input  wire logic                              adapter_one_present,
   input  wire logic                              input_bus_present,
   input  wire logic [CHARGE_STATUS_WIDTH-1:0]    charge_status,
   input  wire logic [OPTIMIZER_STATUS_WIDTH-1:0] optimizer_status,
   input  wire logic [BUS_STATUS_WIDTH-1:0]       input_bus_status,
   input  wire logic                              thermal_regulation,
   input  wire logic                              battery_present,
   input  wire logic [DETECT_STATUS_WIDTH-1:0]    charger_detect_status,
   input  wire logic                              data_line_detect_done,
   input  wire logic                              adc_one_shot_mode,
   input  wire logic                              adc_conversion_done,
   input  wire logic                              min_system_voltage_reg,
   input  wire logic                              fast_charge_timer_expired,
   input  wire logic                              trickle_timer_expired,
   input  wire logic                              precharge_timer_expired,
   input  wire logic                              topoff_timer_expired,
   input  wire logic [7:0]                        reg_addr,
   input  wire logic                              reg_read,
   input  wire logic                              reg_write,
   input  wire logic [7:0]                        reg_wdata,
   output logic [7:0]                             reg_rdata,
   output logic                                   reg_read_valid
);

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      addr_hit = (addr == offset);
   endfunction : addr_hit

   logic ev_adapter_one;
   logic ev_input_bus_present;
   logic ev_charge_state;
   logic ev_optimizer;
   logic ev_bus_state;
   logic ev_thermal;
   logic ev_battery;
   logic ev_detect;
   logic ev_data_line;
   logic ev_conversion;
   logic ev_min_sys;
   logic ev_fast_timer;
   logic ev_trickle_timer;
   logic ev_pre_timer;
   logic ev_topoff_timer;

   change_detector #(
      .WIDTH(1),
      .MODE (detect_any_change)
   ) u_adapter_one (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (adapter_one_present),
      .event_pulse(ev_adapter_one)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_any_change)
   ) u_bus_present (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (input_bus_present),
      .event_pulse(ev_input_bus_present)
   );

   change_detector #(
      .WIDTH(CHARGE_STATUS_WIDTH),
      .MODE (detect_any_change)
   ) u_charge (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (charge_status),
      .event_pulse(ev_charge_state)
   );
   change_detector #(
      .WIDTH(OPTIMIZER_STATUS_WIDTH),
      .MODE (detect_any_change)
   ) u_opt (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (optimizer_status),
      .event_pulse(ev_optimizer)
   );
   change_detector #(
      .WIDTH(BUS_STATUS_WIDTH),
      .MODE (detect_any_change)
   ) u_bus_state (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (input_bus_status),
      .event_pulse(ev_bus_state)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_thermal (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (thermal_regulation),
      .event_pulse(ev_thermal)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_any_change)
   ) u_battery (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (battery_present),
      .event_pulse(ev_battery)
   );
   change_detector #(
      .WIDTH(DETECT_STATUS_WIDTH),
      .MODE (detect_any_change)
   ) u_detect (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (charger_detect_status),
      .event_pulse(ev_detect)
   );

   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_data_line (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (data_line_detect_done),
      .event_pulse(ev_data_line)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_conversion (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (adc_conversion_done),
      .event_pulse(ev_conversion)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_any_change)
   ) u_min_sys (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (min_system_voltage_reg),
      .event_pulse(ev_min_sys)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_fast_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (fast_charge_timer_expired),
      .event_pulse(ev_fast_timer)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_trickle_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (trickle_timer_expired),
      .event_pulse(ev_trickle_timer)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_pre_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (precharge_timer_expired),
      .event_pulse(ev_pre_timer)
   );
   change_detector #(
      .WIDTH(1),
      .MODE (detect_rising_edge)
   ) u_topoff_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .status     (topoff_timer_expired),
      .event_pulse(ev_topoff_timer)
   );

   reg_byte_t flags_zero_reg;
   reg_byte_t flags_zero_next;
   reg_byte_t flags_one_reg;
   reg_byte_t flags_one_next;
   reg_byte_t flags_two_reg;
   reg_byte_t flags_two_next;
   reg_byte_t set_zero;
   reg_byte_t set_one;
   reg_byte_t set_two;
   reg_byte_t rdata_reg;
   reg_byte_t rdata_next;
   logic      read_valid_reg;
   logic      read_valid_next;
   logic      clear_zero;
   logic      clear_one;
   logic      clear_two;

   // one-cycle set request per implemented flag bit
   always_comb begin
      set_zero = '0;
      set_one  = '0;
      set_two  = '0;
      set_zero[`BIT_ADAPTER_ONE_PRESENCE] = ev_adapter_one;
      set_zero[`BIT_INPUT_BUS_PRESENCE]   = ev_input_bus_present;
      set_one[`BIT_CHARGE_STATE]          = ev_charge_state;
      set_one[`BIT_CURRENT_OPTIMIZER]     = ev_optimizer;
      set_one[`BIT_INPUT_BUS_STATE]       = ev_bus_state;
      set_one[`BIT_THERMAL_REGULATION]    = ev_thermal;
      set_one[`BIT_BATTERY_PRESENCE]      = ev_battery;
      set_one[`BIT_CHARGER_DETECT]        = ev_detect;
      set_two[`BIT_DATA_LINE_DONE]        = ev_data_line;
      set_two[`BIT_CONVERSION_DONE]       = ev_conversion && adc_one_shot_mode;
      set_two[`BIT_MIN_SYSTEM_VOLTAGE]    = ev_min_sys;
      set_two[`BIT_FAST_CHARGE_TIMEOUT]   = ev_fast_timer;
      set_two[`BIT_TRICKLE_TIMEOUT]       = ev_trickle_timer;
      set_two[`BIT_PRECHARGE_TIMEOUT]     = ev_pre_timer;
      set_two[`BIT_TOPOFF_TIMEOUT]        = ev_topoff_timer;
   end

   // only reads clear; reg_write and reg_wdata are accepted and ignored;
   // an event in the clearing cycle survives the read
   always_comb begin
      clear_zero      = reg_read && addr_hit(reg_addr, `FLAGS_ZERO_OFFSET);
      flags_zero_next = ((clear_zero ? '0 : flags_zero_reg) | set_zero) & `FLAGS_ZERO_MASK;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags_zero_reg <= `FLAGS_RESET_VALUE;
      end else begin
         flags_zero_reg <= flags_zero_next;
      end
   end

   always_comb begin
      clear_one      = reg_read && addr_hit(reg_addr, `FLAGS_ONE_OFFSET);
      flags_one_next = ((clear_one ? '0 : flags_one_reg) | set_one) & `FLAGS_ONE_MASK;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags_one_reg <= `FLAGS_RESET_VALUE;
      end else begin
         flags_one_reg <= flags_one_next;
      end
   end

   always_comb begin
      clear_two      = reg_read && addr_hit(reg_addr, `FLAGS_TWO_OFFSET);
      flags_two_next = ((clear_two ? '0 : flags_two_reg) | set_two) & `FLAGS_TWO_MASK;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags_two_reg <= `FLAGS_RESET_VALUE;
      end else begin
         flags_two_reg <= flags_two_next;
      end
   end

   // read port: data captured on the strobe and held until the next read
   always_comb begin
      rdata_next      = rdata_reg;
      read_valid_next = reg_read;
      if (reg_read) begin
         if (clear_zero) begin
            rdata_next = flags_zero_reg;
         end else if (clear_one) begin
            rdata_next = flags_one_reg;
         end else if (clear_two) begin
            rdata_next = flags_two_reg;
         end else begin
            rdata_next = `FLAGS_RESET_VALUE;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg      <= `FLAGS_RESET_VALUE;
         read_valid_reg <= 1'b0;
      end else begin
         rdata_reg      <= rdata_next;
         read_valid_reg <= read_valid_next;
      end
   end

   assign reg_rdata      = rdata_reg;
   assign reg_read_valid = read_valid_reg;

endmodule : charger_event_flag_bank

// ### verification/flag_bank_chk.sv
module flag_bank_chk #(
   parameter int CHARGE_STATUS_WIDTH = 3
) (
   input wire logic                           clock,
   input wire logic                           rst_n,
   input wire logic [CHARGE_STATUS_WIDTH-1:0] charge_status,
   input wire logic                           fast_charge_timer_expired,
   input wire logic [7:0]                     reg_addr,
   input wire logic                           reg_read,
   input wire logic [7:0]                     reg_rdata,
   input wire logic                           reg_read_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic primed_reg;
   wire  rd_one = reg_read && reg_addr == 8'h23;
   wire  rd_two = reg_read && reg_addr == 8'h24;
   // the first edge after reset only primes the detectors
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) primed_reg <= 1'b0;
      else primed_reg <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_valid; reg_read |=> reg_read_valid; endproperty
   a_valid: assert property (p_valid) else $error("read answer missing");
   property p_quiet; !reg_read |=> !reg_read_valid && $stable(reg_rdata); endproperty
   a_quiet: assert property (p_quiet) else $error("read data moved without a read");
   property p_rsv1; rd_one |=> reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0; endproperty
   a_rsv1: assert property (p_rsv1) else $error("reserved bit set at 0x23");
   property p_rsv2; rd_two |=> reg_rdata[7] == 1'b0; endproperty
   a_rsv2: assert property (p_rsv2) else $error("reserved bit set at 0x24");
   property p_zero; reg_read && reg_addr == 8'h22 |=> reg_rdata[7:2] == 6'h00; endproperty
   a_zero: assert property (p_zero) else $error("unused bit set at 0x22");
   property p_unmap; reg_read && !(reg_addr inside {[8'h22:8'h24]}) |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_chg; primed_reg && $changed(charge_status) ##1 rd_one |=> reg_rdata[7]; endproperty
   a_chg: assert property (p_chg) else $error("charge change not flagged");
   property p_fast; primed_reg && $rose(fast_charge_timer_expired) ##1 rd_two |=> reg_rdata[3]; endproperty
   a_fast: assert property (p_fast) else $error("fast timer edge not flagged");
   property p_clear;
      rd_one && $stable(charge_status) ##1 $stable(charge_status)
         ##1 rd_one && $stable(charge_status) |=> !reg_rdata[7];
   endproperty
   a_clear: assert property (p_clear) else $error("flag survived its read");
endmodule : flag_bank_chk

bind charger_event_flag_bank flag_bank_chk #(.CHARGE_STATUS_WIDTH(CHARGE_STATUS_WIDTH)) u_chk (
   .clock(clock), .rst_n(rst_n), .charge_status(charge_status),
   .fast_charge_timer_expired(fast_charge_timer_expired), .reg_addr(reg_addr),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_read_valid(reg_read_valid)
);

// ### verification/host_reader.sv
module host_reader (
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_read_valid,
   output logic [7:0]      reg_addr,
   output logic            reg_read,
   output logic            reg_write,
   output logic [7:0]      reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 8'h00;
      reg_read = 1'b0;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
   end
   // released lines show the inverse of their last value
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      v = reg_read_valid;
      d = reg_rdata;
   endtask : read
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : write
endmodule : host_reader

// ### verification/tb_charger_event_flag_bank.sv
module tb_charger_event_flag_bank;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock;
   logic        rst_n;
   logic        one_shot;
   logic [21:0] stat;
   logic [7:0]  reg_addr;
   logic        reg_read;
   logic        reg_write;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_read_valid;
   int          failures;
   int          n_compared;
   int          cycles;

   charger_event_flag_bank u_dut (
      .clock(clock), .rst_n(rst_n), .input_bus_present(stat[0]),
      .adapter_one_present(stat[1]), .battery_present(stat[2]), .thermal_regulation(stat[3]),
      .data_line_detect_done(stat[4]), .adc_conversion_done(stat[5]),
      .min_system_voltage_reg(stat[6]), .fast_charge_timer_expired(stat[7]),
      .trickle_timer_expired(stat[8]), .precharge_timer_expired(stat[9]),
      .topoff_timer_expired(stat[10]), .charger_detect_status(stat[12:11]),
      .charge_status(stat[15:13]), .optimizer_status(stat[17:16]),
      .input_bus_status(stat[21:18]), .adc_one_shot_mode(one_shot), .reg_addr(reg_addr),
      .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_read_valid(reg_read_valid)
   );
   host_reader u_host (
      .clock(clock), .reg_rdata(reg_rdata), .reg_read_valid(reg_read_valid),
      .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic summarize;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         summarize();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      u_host.read(a, d, v);
      chk("read_valid", 8'h01, {7'h00, v});
      chk($sformatf("reg_%h", a), e, d);
   endtask : rd

   // flip inputs, read the flag, then read again to see it cleared
   task automatic ev(input logic [21:0] f, input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      stat <= stat ^ f;
      rd(a, e);
      rd(a, 8'h00);
   endtask : ev

   task automatic t_reset;
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h00);
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      rd(8'h00, 8'h00);
   endtask : t_reset

   task automatic t_change;
      ev(22'h00_0001, 8'h22, 8'h01);
      ev(22'h00_0001, 8'h22, 8'h01);
      ev(22'h00_0002, 8'h22, 8'h02);
      ev(22'h00_0004, 8'h23, 8'h02);
      ev(22'h00_1000, 8'h23, 8'h01);
      ev(22'h00_8000, 8'h23, 8'h80);
      ev(22'h01_0000, 8'h23, 8'h40);
      ev(22'h20_0000, 8'h23, 8'h10);
      ev(22'h00_0040, 8'h24, 8'h10);
      ev(22'h00_0040, 8'h24, 8'h10);
   endtask : t_change

   task automatic t_edges;
      ev(22'h00_0008, 8'h23, 8'h04);
      ev(22'h00_0008, 8'h23, 8'h00);
      ev(22'h00_0010, 8'h24, 8'h40);
      ev(22'h00_0010, 8'h24, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ev(22'h00_0080 << i, 8'h24, 8'h08 >> i);
         ev(22'h00_0080 << i, 8'h24, 8'h00);
      end
   endtask : t_edges

   task automatic t_adc;
      ev(22'h00_0020, 8'h24, 8'h00);
      ev(22'h00_0020, 8'h24, 8'h00);
      @(posedge clock);
      one_shot <= 1'b1;
      ev(22'h00_0020, 8'h24, 8'h20);
      ev(22'h00_0020, 8'h24, 8'h00);
   endtask : t_adc

   task automatic t_write;
      @(posedge clock);
      stat <= stat ^ 22'h00_8000;
      u_host.write(8'h23, 8'h00);
      u_host.write(8'h24, 8'hff);
      rd(8'h23, 8'h80);
      rd(8'h24, 8'h00);
   endtask : t_write

   // an event landing on the reading edge must survive that read
   task automatic t_race;
      logic [7:0] d;
      logic       v;
      fork
         u_host.read(8'h23, d, v);
         begin
            @(posedge clock);
            stat <= stat ^ 22'h00_0004;
         end
      join
      chk("read_valid", 8'h01, {7'h00, v});
      chk("reg_23", 8'h00, d);
      rd(8'h23, 8'h02);
      rd(8'h23, 8'h00);
   endtask : t_race

   initial begin
      rst_n = 1'b0;
      stat = 22'h00_0000;
      one_shot = 1'b0;
      failures = 0;
      n_compared = 0;
      cycles = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_change();
      t_edges();
      t_adc();
      t_write();
      t_race();
      summarize();
   end
endmodule : tb_charger_event_flag_bank
